// [pkg/rtc_pkg.sv]
// shared constants, register map and carrier types of the clock core
package rtc_pkg;

  // ********************
  // timing
  // ********************
  localparam int CLK_HZ = 25_000_000;
  localparam int BASE_HZ = 1024;
  localparam int BASE_CYC = CLK_HZ / BASE_HZ;
  localparam int HALF_SEC_TICKS = 512;
  localparam int SEC_TICKS = 1024;
  localparam int START_GUARD_US = 60;
  localparam int START_GUARD_CYC = (START_GUARD_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int CAL_SLOW_SECS = 960;
  localparam int CAL_FAST_SECS = 480;

  // ********************
  // register map
  // ********************
  localparam logic [6:0] DEV_ADDR = 7'h68;
  localparam logic [7:0] OFF_TIME_SECONDS = 8'h00;
  localparam logic [7:0] OFF_TIME_MINUTES = 8'h01;
  localparam logic [7:0] OFF_HOURS_CENTURY = 8'h02;
  localparam logic [7:0] OFF_WEEKDAY = 8'h03;
  localparam logic [7:0] OFF_DAY_OF_MONTH = 8'h04;
  localparam logic [7:0] OFF_MONTH_OF_YEAR = 8'h05;
  localparam logic [7:0] OFF_YEAR_COUNT = 8'h06;
  localparam logic [7:0] OFF_CALIBRATION_CONFIG = 8'h07;
  localparam logic [7:0] OFF_CONFIG_SECOND = 8'h09;
  localparam logic [7:0] OFF_SPECIAL_KEY_FIRST = 8'h20;
  localparam logic [7:0] OFF_SPECIAL_FUNCTION = 8'h22;
  localparam int NUM_REGS = 12;
  localparam logic [3:0] IDX_SECONDS = 4'h0;
  localparam logic [3:0] IDX_MINUTES = 4'h1;
  localparam logic [3:0] IDX_WEEKDAY = 4'h3;
  localparam logic [3:0] IDX_DAY_OF_MONTH = 4'h4;
  localparam logic [3:0] IDX_MONTH_OF_YEAR = 4'h5;
  localparam logic [3:0] IDX_CAL = 4'h7;
  localparam logic [3:0] IDX_CONFIG_SECOND = 4'h8;
  localparam logic [3:0] IDX_LAST_TIME = 4'h8;
  localparam logic [3:0] IDX_NONE = 4'hf;

  // ********************
  // fields and reset values
  // ********************
  localparam int OSC_HALT_BIT = 7;
  localparam int OUT_LEVEL_BIT = 7;
  localparam int FT_ENABLE_BIT = 6;
  localparam int CAL_SIGN_BIT = 5;
  localparam int FT_SELECT_BIT = 6;
  localparam logic [7:0] CAL_CFG_RESET = 8'h80;
  localparam logic [7:0] OTHER_RESET = 8'h00;
  localparam logic [7:0] KEEP_MINUTES = 8'h7f;
  localparam logic [7:0] KEEP_WEEKDAY = 8'h07;
  localparam logic [7:0] KEEP_DAY = 8'h3f;
  localparam logic [7:0] KEEP_MONTH = 8'h1f;
  localparam logic [7:0] KEEP_FT = 8'hbf;
  localparam logic [7:0] KEEP_ALL = 8'hff;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b011,
    ST_WRITE_BYTE = 3'b010,
    ST_WRITE_ACK = 3'b110,
    ST_READ_BYTE = 3'b111,
    ST_READ_ACK = 3'b101
  } slave_state_e;

  typedef struct packed {
    logic out;
    logic oe;
  } od_pin_s;

  function automatic logic [3:0] reg_index(input logic [7:0] off);
    if (off <= OFF_CALIBRATION_CONFIG) return off[3:0];
    if (off == OFF_CONFIG_SECOND) return IDX_CONFIG_SECOND;
    if (off >= OFF_SPECIAL_KEY_FIRST && off <= OFF_SPECIAL_FUNCTION)
      return 4'(off - OFF_SPECIAL_KEY_FIRST) + 4'h9;
    return IDX_NONE;
  endfunction

  function automatic logic [7:0] keep_mask(input logic [3:0] idx);
    case (idx)
      IDX_MINUTES: return KEEP_MINUTES;
      IDX_WEEKDAY: return KEEP_WEEKDAY;
      IDX_DAY_OF_MONTH: return KEEP_DAY;
      IDX_MONTH_OF_YEAR: return KEEP_MONTH;
      IDX_CAL, IDX_CONFIG_SECOND: return KEEP_FT;
      default: return KEEP_ALL;
    endcase
  endfunction

endpackage

// [src/sync_pair.sv]
// two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module sync_pair #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // every synced line idles high: pulled-up bus pins, comparators up on main supply;
      // a low reset value would fake a bus edge and a backup episode after reset
      meta <= '1;
      q <= '1;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// [src/pulse_divider.sv]
// free-running divider giving one-cycle pulses every CYC clocks
`timescale 1ns/1ps
module pulse_divider #(
  parameter int CYC = 24414
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic tick
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);
  logic [CW-1:0] count;
  wire at_last = (count == LAST);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= at_last ? '0 : count + 1'b1;
      tick <= at_last;
    end
  end
endmodule

// [src/rtc_core.sv]
// clock core: serial slave port, register file, supply switchover and output pin
`timescale 1ns/1ps
module rtc_core
  import rtc_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output od_pin_s sda_pin,
  input wire logic main_above_backup,
  input wire logic main_above_ref,
  output od_pin_s gen_pin,
  output logic on_backup
);

  // ********************
  // pin synchronisers
  // ********************
  logic [3:0] pins_s;
  logic scl_q;
  logic sda_q;

  sync_pair #(.W(4)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({scl_in, sda_in, main_above_backup, main_above_ref}),
    .q(pins_s)
  );

  wire scl_s = pins_s[3];
  wire sda_s = pins_s[2];
  wire backup_now = !pins_s[1] && !pins_s[0];
  wire scl_rise = scl_s && !scl_q;
  wire scl_fall = !scl_s && scl_q;
  wire bus_start = scl_s && scl_q && sda_q && !sda_s;
  wire bus_stop = scl_s && scl_q && !sda_q && sda_s;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // ********************
  // supply switchover
  // ********************
  logic update_pending;
  logic [11:0] guard;
  wire enter_backup = backup_now && !on_backup;
  wire exit_backup = !backup_now && on_backup;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      on_backup <= 1'b0;
      guard <= '0;
    end else begin
      on_backup <= backup_now;
      // starts too soon after recovery are dropped, not half decoded
      if (exit_backup) guard <= 12'(START_GUARD_CYC);
      else if (guard != '0) guard <= guard - 1'b1;
    end
  end

  // ********************
  // time base and calibration
  // ********************
  logic base_tick;
  logic [10:0] tick_cnt;
  logic [9:0] cal_secs;
  logic sq512;

  pulse_divider #(.CYC(BASE_CYCLES)) u_base (
    .clock(clock),
    .rst_n(rst_n),
    .tick(base_tick)
  );

  logic [7:0] regs [NUM_REGS];
  wire [7:0] seconds = regs[IDX_SECONDS];
  wire [7:0] cal_cfg = regs[IDX_CAL];
  wire osc_halt = seconds[OSC_HALT_BIT];
  wire out_level = cal_cfg[OUT_LEVEL_BIT];
  wire ft_en = cal_cfg[FT_ENABLE_BIT];
  wire ft_sel = regs[IDX_CONFIG_SECOND][FT_SELECT_BIT];
  wire cal_sign = cal_cfg[CAL_SIGN_BIT];
  wire [10:0] cal_mag = {6'h00, cal_cfg[4:0]};
  wire [9:0] cal_last = cal_sign ? 10'(CAL_FAST_SECS - 1) : 10'(CAL_SLOW_SECS - 1);
  wire adj_now = (cal_secs == cal_last);
  wire [10:0] sec_len = !adj_now ? 11'(SEC_TICKS)
                      : cal_sign ? 11'(SEC_TICKS) - cal_mag
                      : 11'(SEC_TICKS) + cal_mag;
  wire sec_tick = base_tick && (tick_cnt >= sec_len - 11'h001);
  wire sq1 = (tick_cnt < 11'(HALF_SEC_TICKS));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
      cal_secs <= '0;
      sq512 <= 1'b0;
    end else if (osc_halt) begin
      tick_cnt <= '0;
    end else if (base_tick) begin
      sq512 <= !sq512;
      tick_cnt <= sec_tick ? '0 : tick_cnt + 1'b1;
      if (sec_tick) cal_secs <= adj_now ? '0 : cal_secs + 1'b1;
    end
  end

  // ********************
  // seconds counting and post-backup hold
  // ********************
  logic [7:0] held_sec;
  wire [3:0] units = seconds[3:0];
  wire [2:0] tens = seconds[6:4];
  wire unit_wrap = (units >= 4'h9);
  wire [3:0] next_units = unit_wrap ? 4'h0 : units + 4'h1;
  wire [2:0] next_tens = !unit_wrap ? tens : (tens >= 3'h5) ? 3'h0 : tens + 3'h1;
  wire [7:0] next_seconds = {seconds[OSC_HALT_BIT], next_tens, next_units};
  wire count_now = sec_tick && !osc_halt;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      held_sec <= OTHER_RESET;
      update_pending <= 1'b0;
    end else begin
      if (enter_backup) held_sec <= seconds;
      // set wins: a recovery landing on a tick still waits one second
      if (exit_backup) update_pending <= 1'b1;
      else if (sec_tick) update_pending <= 1'b0;
    end
  end

  // ********************
  // serial slave
  // ********************
  slave_state_e state;
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  logic phase;
  logic rw;
  logic ptr_loaded;
  logic [7:0] pointer;

  wire [7:0] rx_byte = {shift[6:0], sda_s};
  wire addr_match = (shift[7:1] == DEV_ADDR);
  wire [3:0] ptr_idx = reg_index(pointer);
  wire ptr_time = (ptr_idx == IDX_SECONDS);
  wire [7:0] rd_byte = (ptr_idx == IDX_NONE) ? 8'h00
                     : (ptr_time && update_pending) ? held_sec
                     : regs[ptr_idx];
  wire wr_stb = (state == ST_WRITE_ACK) && scl_fall && !phase && ptr_loaded;
  wire ptr_stb = (state == ST_WRITE_ACK) && scl_fall && !phase && !ptr_loaded;
  wire start_ok = bus_start && (guard == '0);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      shift <= '0;
      bit_cnt <= '0;
      phase <= 1'b0;
      rw <= 1'b0;
      ptr_loaded <= 1'b0;
      pointer <= '0;
      sda_pin <= '0;
    end else if (backup_now || bus_stop) begin
      state <= ST_IDLE;
      sda_pin.oe <= 1'b0;
    end else if (start_ok) begin
      state <= ST_ADDR;
      bit_cnt <= '0;
      ptr_loaded <= 1'b0;
      sda_pin.oe <= 1'b0;
    end else begin
      // bus clock is only ever sampled; no path drives it
      case (state)
        ST_ADDR, ST_WRITE_BYTE: begin
          if (scl_rise) begin
            shift <= rx_byte;
            bit_cnt <= bit_cnt + 1'b1;
            phase <= 1'b0;
            if (bit_cnt == 3'h7) state <= (state == ST_ADDR) ? ST_ADDR_ACK : ST_WRITE_ACK;
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall && !phase) begin
            // general call and foreign addresses fall back to idle
            if (addr_match) begin
              sda_pin.oe <= 1'b1;
              rw <= shift[0];
              phase <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end else if (scl_fall) begin
            phase <= 1'b0;
            bit_cnt <= '0;
            if (rw) begin
              shift <= rd_byte;
              sda_pin.oe <= !rd_byte[7];
              state <= ST_READ_BYTE;
            end else begin
              sda_pin.oe <= 1'b0;
              state <= ST_WRITE_BYTE;
            end
          end
        end
        ST_WRITE_ACK: begin
          if (scl_fall && !phase) begin
            sda_pin.oe <= 1'b1;
            phase <= 1'b1;
            ptr_loaded <= 1'b1;
            pointer <= ptr_loaded ? pointer + 8'h01 : shift;
          end else if (scl_fall) begin
            sda_pin.oe <= 1'b0;
            phase <= 1'b0;
            state <= ST_WRITE_BYTE;
          end
        end
        ST_READ_BYTE: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == 3'h7) begin
              state <= ST_READ_ACK;
              phase <= 1'b0;
              pointer <= pointer + 8'h01;
            end
          end else if (scl_fall) begin
            shift <= {shift[6:0], 1'b0};
            sda_pin.oe <= !shift[6];
          end
        end
        ST_READ_ACK: begin
          if (scl_fall && !phase) begin
            sda_pin.oe <= 1'b0;
          end else if (scl_rise) begin
            if (sda_s) state <= ST_IDLE;
            else phase <= 1'b1;
          end else if (scl_fall) begin
            phase <= 1'b0;
            bit_cnt <= '0;
            shift <= rd_byte;
            sda_pin.oe <= !rd_byte[7];
            state <= ST_READ_BYTE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ********************
  // register file
  // ********************
  wire [3:0] wr_idx = reg_index(pointer);
  wire wr_hit = wr_stb && (wr_idx != IDX_NONE);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= (4'(i) == IDX_CAL) ? CAL_CFG_RESET : OTHER_RESET;
      end
    end else if (enter_backup) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= regs[i] & keep_mask(4'(i));
      end
    end else begin
      if (count_now) regs[IDX_SECONDS] <= next_seconds;
      if (wr_hit) regs[wr_idx] <= shift;
    end
  end

  // ********************
  // general output pin
  // ********************
  wire gen_level = ft_en ? (ft_sel ? sq1 : sq512) : out_level;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gen_pin <= '0;
    end else begin
      gen_pin.out <= 1'b0;
      gen_pin.oe <= !backup_now && !gen_level;
    end
  end

  // ********************
  // checks
  // ********************
  a_bus_off_backup: assert property (@(posedge clock) disable iff (!rst_n)
    on_backup |-> !sda_pin.oe) else $error("bus driven while on backup");

  a_pin_off_backup: assert property (@(posedge clock) disable iff (!rst_n)
    on_backup |-> !gen_pin.oe) else $error("output pin active on backup");

  a_static_level: assert property (@(posedge clock) disable iff (!rst_n)
    (!ft_en && !backup_now) |=> (gen_pin.oe == !$past(out_level)))
    else $error("static output level wrong");

  a_fast_square: assert property (@(posedge clock) disable iff (!rst_n)
    (base_tick && !osc_halt) |=> (sq512 != $past(sq512)))
    else $error("512 Hz square did not toggle");

  a_backup_clears_ft: assert property (@(posedge clock) disable iff (!rst_n)
    enter_backup |=> (!ft_en && !ft_sel && (out_level == $past(out_level))))
    else $error("test bits survived backup entry");

  a_halt_freezes_time: assert property (@(posedge clock) disable iff (!rst_n)
    (osc_halt && !wr_hit && !enter_backup) |=> $stable(seconds[6:0]))
    else $error("seconds moved while halted");

  a_tick_advances: assert property (@(posedge clock) disable iff (!rst_n)
    (count_now && !wr_hit && !enter_backup) |=> (seconds != $past(seconds)))
    else $error("seconds not advanced on tick");

  a_guard_drops_start: assert property (@(posedge clock) disable iff (!rst_n)
    (bus_start && guard != '0 && !backup_now && !bus_stop && state == ST_IDLE)
      |=> (state == ST_IDLE)) else $error("start taken inside guard time");

  a_addr_ack: assert property (@(posedge clock) disable iff (!rst_n)
    (state == ST_ADDR_ACK && scl_fall && !phase && addr_match && !backup_now && !bus_stop
      && !start_ok) |=> sda_pin.oe) else $error("own address not acknowledged");

  a_hold_read: assert property (@(posedge clock) disable iff (!rst_n)
    (update_pending && ptr_time) |-> (rd_byte == held_sec))
    else $error("time read during update not held");

endmodule

// [tb/i2c_host_model.sv]
// host model: bus master that drives the serial clock and pulls the data line
`timescale 1ns/1ps
module i2c_host_model (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // ********************
  // bit timing
  // ********************
  // a quarter is two system clocks, so one bus period is 320 ns
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic quarter();
    repeat (2) @(negedge clock);
  endtask

  // also a repeated start: data is released before the clock rises
  task automatic start_cond();
    quarter();
    sda_low = 1'b0;
    quarter();
    scl = 1'b1;
    quarter();
    sda_low = 1'b1;
    quarter();
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    quarter();
    sda_low = 1'b1;
    quarter();
    scl = 1'b1;
    quarter();
    sda_low = 1'b0;
    quarter();
  endtask

  task automatic bit_xfer(input logic b, output logic got);
    quarter();
    sda_low = !b;
    quarter();
    scl = 1'b1;
    quarter();
    got = sda;
    quarter();
    scl = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(v[i], g);
    end
    bit_xfer(1'b1, g);
    ack = (g === 1'b0);
  endtask

  // line left high on the last byte to end the read
  task automatic recv_byte(input logic last, output logic [7:0] v);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, v[i]);
    end
    bit_xfer(last, g);
  endtask
endmodule

// [tb/rtc_host_port_and_pin_control_tb.sv]
// self-checking bench: bus access, output pin and supply switchover of the clock core
`timescale 1ns/1ps
module rtc_host_port_and_pin_control_tb;
  import rtc_pkg::*;
  localparam int BASE_TB = 4;
  localparam int SEC_CLK = BASE_TB * SEC_TICKS;
  logic clock, rst_n, scl, sda_low, sda, above_bk, above_ref, on_backup, ack;
  od_pin_s sda_pin, gen_pin;
  logic [7:0] rd;
  int n;
  int err_total = 0;
  int tests_run = 0;

  assign sda = !(sda_pin.oe | sda_low);

  rtc_core #(.BASE_CYCLES(BASE_TB)) dut_u (
    .clock(clock),
    .rst_n(rst_n),
    .scl_in(scl),
    .sda_in(sda),
    .sda_pin(sda_pin),
    .main_above_backup(above_bk),
    .main_above_ref(above_ref),
    .gen_pin(gen_pin),
    .on_backup(on_backup)
  );
  i2c_host_model host_u (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));

  // ********************
  // helpers
  // ********************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    check({7'h0, got}, {7'h0, exp});
  endtask

  task automatic reg_write(input logic [7:0] ptr, input logic [7:0] v);
    host_u.start_cond();
    host_u.send_byte(8'hd0, ack);
    chk_bit(ack, 1'b1);
    host_u.send_byte(ptr, ack);
    host_u.send_byte(v, ack);
    chk_bit(ack, 1'b1);
    host_u.stop_cond();
  endtask

  task automatic open_read(input logic [7:0] ptr);
    host_u.start_cond();
    host_u.send_byte(8'hd0, ack);
    host_u.send_byte(ptr, ack);
    host_u.start_cond();
    host_u.send_byte(8'hd1, ack);
    chk_bit(ack, 1'b1);
  endtask

  task automatic reg_read(input logic [7:0] ptr, output logic [7:0] v);
    open_read(ptr);
    host_u.recv_byte(1'b1, v);
    host_u.stop_cond();
  endtask

  task automatic try_addr(input logic [7:0] a, input logic exp);
    host_u.start_cond();
    host_u.send_byte(a, ack);
    chk_bit(ack, exp);
    host_u.stop_cond();
  endtask

  task automatic count_rises(input int cycles, output int cnt);
    logic prev;
    cnt = 0;
    prev = gen_pin.oe;
    repeat (cycles) begin
      @(negedge clock);
      if (gen_pin.oe && !prev) begin
        cnt++;
      end
      prev = gen_pin.oe;
    end
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_reset();
    reg_read(8'h07, rd);
    check(rd, 8'h80);
    reg_read(8'h09, rd);
    check(rd, 8'h00);
    reg_read(8'h00, rd);
    chk_bit(rd[7], 1'b0);
    chk_bit(gen_pin.oe, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_map();
    host_u.start_cond();
    host_u.send_byte(8'hd0, ack);
    host_u.send_byte(8'h20, ack);
    host_u.send_byte(8'ha5, ack);
    host_u.send_byte(8'h5a, ack);
    host_u.send_byte(8'hc3, ack);
    host_u.stop_cond();
    open_read(8'h20);
    host_u.recv_byte(1'b0, rd);
    check(rd, 8'ha5);
    host_u.recv_byte(1'b0, rd);
    check(rd, 8'h5a);
    host_u.recv_byte(1'b1, rd);
    check(rd, 8'hc3);
    host_u.stop_cond();
    reg_write(8'h08, 8'h55);
    reg_read(8'h08, rd);
    check(rd, 8'h00);
    try_addr(8'h00, 1'b0);
    try_addr(8'hd2, 1'b0);
    host_u.start_cond();
    host_u.send_byte(8'hd0, ack);
    host_u.send_byte(8'h21, ack);
    repeat (4) host_u.bit_xfer(1'b0, ack);
    host_u.stop_cond();
    reg_read(8'h21, rd);
    check(rd, 8'h5a);
    $display("test map done");
  endtask

  task automatic t_pin();
    reg_write(8'h07, 8'h00);
    reg_write(8'h09, 8'h40);
    chk_bit(gen_pin.oe, 1'b1);
    reg_write(8'h07, 8'h80);
    chk_bit(gen_pin.oe, 1'b0);
    reg_write(8'h07, 8'h40);
    count_rises(SEC_CLK * 2, n);
    chk_bit(n >= 1 && n <= 3, 1'b1);
    reg_write(8'h09, 8'h00);
    count_rises(SEC_CLK, n);
    chk_bit(n >= 511 && n <= 513, 1'b1);
    $display("test pin done");
  endtask

  // ft on with level low going in, so a kept level shows as a driven pin after
  task automatic t_backup();
    reg_write(8'h09, 8'h40);
    reg_write(8'h01, 8'hff);
    reg_write(8'h00, 8'ha5);
    above_ref = 1'b0;
    repeat (10) @(negedge clock);
    chk_bit(on_backup, 1'b0);
    above_bk = 1'b0;
    repeat (10) @(negedge clock);
    chk_bit(on_backup, 1'b1);
    chk_bit(gen_pin.oe, 1'b0);
    try_addr(8'hd0, 1'b0);
    above_ref = 1'b1;
    repeat (10) @(negedge clock);
    chk_bit(on_backup, 1'b0);
    try_addr(8'hd0, 1'b0);
    repeat (SEC_CLK + 100) @(negedge clock);
    reg_read(8'h07, rd);
    check(rd, 8'h00);
    reg_read(8'h09, rd);
    check(rd, 8'h00);
    reg_read(8'h01, rd);
    check(rd, 8'h7f);
    reg_read(8'h00, rd);
    check(rd, 8'ha5);
    chk_bit(gen_pin.oe, 1'b1);
    above_bk = 1'b1;
    $display("test backup done");
  endtask

  task automatic t_count();
    reg_write(8'h07, 8'h80);
    reg_write(8'h00, 8'h59);
    repeat (SEC_CLK + 1000) @(negedge clock);
    reg_read(8'h00, rd);
    chk_bit(rd === 8'h00 || rd === 8'h01, 1'b1);
    $display("test count done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ********************
  // run
  // ********************
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    repeat (90000) @(posedge clock);
    err_total++;
    $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    above_bk = 1'b1;
    above_ref = 1'b1;
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    repeat (5) @(negedge clock);
    t_reset();
    t_map();
    t_pin();
    t_backup();
    t_count();
    tally_and_finish();
  end
endmodule
